// File: common/tmz_pkg.sv
package tmz_pkg;
    // register bus geometry
    localparam int          TMZ_AW         = 12;
    localparam int          TMZ_DW         = 32;
    // register indices as printed, byte address is four times the index
    localparam logic [11:0] TMZ_IDX_CNT    = 12'h001;
    localparam logic [11:0] TMZ_IDX_ICTL   = 12'h00b;
    localparam logic [11:0] TMZ_IDX_CFG    = 12'h081;
    localparam logic [11:0] TMZ_IDX_STAT   = 12'h090;
    localparam logic [11:0] TMZ_IDX_MASK   = 12'h091;
    localparam logic [11:0] TMZ_ADDR_CNT   = TMZ_IDX_CNT << 2;
    localparam logic [11:0] TMZ_ADDR_ICTL  = TMZ_IDX_ICTL << 2;
    localparam logic [11:0] TMZ_ADDR_CFG   = TMZ_IDX_CFG << 2;
    localparam logic [11:0] TMZ_ADDR_STAT  = TMZ_IDX_STAT << 2;
    localparam logic [11:0] TMZ_ADDR_MASK  = TMZ_IDX_MASK << 2;
    // timer_config_options fields
    localparam int          TMZ_CFG_SRC    = 5;
    localparam int          TMZ_CFG_EDGE   = 4;
    localparam int          TMZ_CFG_PSA    = 3;
    localparam int          TMZ_CFG_RATE   = 0;
    // interrupt_control fields
    localparam int          TMZ_ICTL_IE    = 5;
    localparam int          TMZ_ICTL_IF    = 2;
    // status / mask fields
    localparam int          TMZ_ST_OVF     = 0;
    localparam int          TMZ_ST_WDT     = 1;
    // reset values
    localparam logic [7:0]  TMZ_CFG_RST    = 8'hff;
    localparam logic [7:0]  TMZ_ICTL_RST   = 8'h00;
    localparam logic [7:0]  TMZ_CNT_RST    = 8'h00;
    localparam logic [1:0]  TMZ_IRQ_RST    = 2'h0;
    // cycle counts
    localparam int          TMZ_INSN_DIV   = 4;
    localparam logic [1:0]  TMZ_INH_CYC    = 2'h2;
    // bus answers
    localparam logic [1:0]  TMZ_RESP_OK    = 2'h0;
    localparam logic [1:0]  TMZ_RESP_ERR   = 2'h2;
endpackage

// File: design/tmz_timer.sv
`timescale 1ns/1ns
`default_nettype none
module tmz_timer #(
    parameter int INSN_DIV = tmz_pkg::TMZ_INSN_DIV
) (
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    input  wire logic                       external_count_pin,
    input  wire logic                       wdt_base_tick,
    output logic                            wdt_scaled_tick,
    output logic                            overflow_irq,
    output logic                            irq,
    input  wire logic [tmz_pkg::TMZ_AW-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [tmz_pkg::TMZ_DW-1:0] s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [tmz_pkg::TMZ_AW-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [tmz_pkg::TMZ_DW-1:0]      s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready
);
    import tmz_pkg::*;

    logic [7:0]        cfg_r;
    logic [7:0]        ictl_r;
    logic [7:0]        cnt_r;
    logic [7:0]        psc_r;
    logic [1:0]        stat_r;
    logic [1:0]        mask_r;
    logic [1:0]        inh_r;
    logic [7:0]        div_r;
    logic              insn_tick;
    logic [2:0]        pin_r;
    logic              aw_full_r;
    logic              w_full_r;
    logic [TMZ_AW-1:0] awaddr_r;
    logic [7:0]        wdata_r;
    logic              wstrb_r;
    logic              wdt_r;
    logic              ovf_irq_r;
    logic              irq_r;

    // instruction-cycle enable from the fast clock
    always_ff @(posedge core_clk) begin
        if (rst || div_r == 8'(INSN_DIV - 1)) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end
    assign insn_tick = (div_r == 8'(INSN_DIV - 1));

    // pin synchroniser; stage 0 feeds only stage 1, stage 2 is edge history
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_r <= 3'h0;
        end else begin
            pin_r <= {pin_r[1:0], external_count_pin};
        end
    end

    // configuration fields and edge decode
    wire       cfg_src  = cfg_r[TMZ_CFG_SRC];
    wire       cfg_edge = cfg_r[TMZ_CFG_EDGE];
    wire       cfg_psa  = cfg_r[TMZ_CFG_PSA];
    wire [2:0] cfg_rate = cfg_r[TMZ_CFG_RATE +: 3];
    wire       pin_rise = pin_r[1] & ~pin_r[2];
    wire       pin_fall = ~pin_r[1] & pin_r[2];
    wire       ext_ev   = cfg_edge ? pin_fall : pin_rise;
    wire       src_ev   = cfg_src ? ext_ev : insn_tick;

    // one prescaler, fed by whichever owner holds it
    wire       psc_in   = cfg_psa ? wdt_base_tick : src_ev;
    // low rate+1 bits all ones ends a timer period
    wire [7:0] tmr_mask = 8'hff >> (3'd7 - cfg_rate);
    // watchdog side drops one stage, rate 0 passes through
    wire [7:0] wdt_mask = tmr_mask >> 1;
    wire [7:0] act_mask = cfg_psa ? wdt_mask : tmr_mask;
    wire       psc_tick = psc_in && ((psc_r & act_mask) == act_mask);

    // register bus decode
    wire [11:0] waddr  = {awaddr_r[TMZ_AW-1:2], 2'b00};
    wire [11:0] raddr  = {s_axi_araddr[TMZ_AW-1:2], 2'b00};
    wire        do_wr  = aw_full_r && w_full_r && !s_axi_bvalid;
    wire        wr_en  = do_wr && wstrb_r;
    wire        w_hit  = (waddr == TMZ_ADDR_CNT) || (waddr == TMZ_ADDR_ICTL)
                      || (waddr == TMZ_ADDR_CFG) || (waddr == TMZ_ADDR_STAT)
                      || (waddr == TMZ_ADDR_MASK);
    wire        cnt_wr = wr_en && (waddr == TMZ_ADDR_CNT);
    wire        ictl_wr = wr_en && (waddr == TMZ_ADDR_ICTL);
    wire        cfg_wr = wr_en && (waddr == TMZ_ADDR_CFG);
    wire        stat_wr = wr_en && (waddr == TMZ_ADDR_STAT);
    wire        mask_wr = wr_en && (waddr == TMZ_ADDR_MASK);
    wire        rd_go  = s_axi_arvalid && s_axi_arready;

    // timer steps on prescaler only when it owns it
    wire       tmr_ev = cfg_psa ? src_ev : psc_tick;
    // blocked while the post-write hold is running
    wire       inc_ev = tmr_ev && (inh_r == 2'h0) && !cnt_wr;
    wire       ovf_ev = inc_ev && (cnt_r == 8'hff);
    wire [1:0] ev_vec = {wdt_r, ovf_ev};
    // prescaler count; a timer-owned prescaler restarts on count writes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            psc_r <= 8'h00;
        end else if (cnt_wr && !cfg_psa) begin
            psc_r <= 8'h00;
        end else if (psc_in) begin
            psc_r <= psc_r + 8'h01;
        end
    end
    // watchdog tick, registered so the output comes from a flop
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wdt_r <= 1'b0;
        end else begin
            // timer owns prescaler: watchdog runs unscaled
            wdt_r <= cfg_psa ? psc_tick : wdt_base_tick;
        end
    end
    // two instruction cycles of hold after a count write
    always_ff @(posedge core_clk) begin
        if (rst) begin
            inh_r <= 2'h0;
        end else if (cnt_wr) begin
            inh_r <= TMZ_INH_CYC;
        end else if (insn_tick && inh_r != 2'h0) begin
            inh_r <= inh_r - 2'h1;
        end
    end
    // count register wraps ff to 00
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_r <= TMZ_CNT_RST;
        end else if (cnt_wr) begin
            cnt_r <= wdata_r;
        end else if (inc_ev) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg_r <= TMZ_CFG_RST;
        end else if (cfg_wr) begin
            cfg_r <= wdata_r;
        end
    end
    // overflow sets the flag; set beats a same-cycle clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ictl_r <= TMZ_ICTL_RST;
        end else if (ictl_wr) begin
            ictl_r <= wdata_r | {5'h00, ovf_ev, 2'h0};
        end else if (ovf_ev) begin
            ictl_r[TMZ_ICTL_IF] <= 1'b1;
        end
    end
    // sticky status, write one to clear, events win over clears
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stat_r <= TMZ_IRQ_RST;
            mask_r <= TMZ_IRQ_RST;
        end else begin
            stat_r <= (stat_r & ~(stat_wr ? wdata_r[1:0] : 2'h0)) | ev_vec;
            if (mask_wr) begin
                mask_r <= wdata_r[1:0];
            end
        end
    end
    // interrupt outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ovf_irq_r <= 1'b0;
            irq_r     <= 1'b0;
        end else begin
            ovf_irq_r <= ictl_r[TMZ_ICTL_IE] && ictl_r[TMZ_ICTL_IF];
            irq_r     <= |(stat_r & mask_r);
        end
    end

    // write channel: address and data taken in either order
    always_ff @(posedge core_clk) begin
        if (rst) begin
            aw_full_r     <= 1'b0;
            w_full_r      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= TMZ_RESP_OK;
            awaddr_r      <= '0;
            wdata_r       <= 8'h00;
            wstrb_r       <= 1'b0;
        end else begin
            s_axi_awready <= !aw_full_r && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_full_r && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r <= 1'b1;
                wdata_r  <= s_axi_wdata[7:0];
                wstrb_r  <= s_axi_wstrb[0];
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= w_hit ? TMZ_RESP_OK : TMZ_RESP_ERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_full_r     <= 1'b0;
                w_full_r      <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready  <= 1'b0;
            end
        end
    end

    // read mux; narrow registers sit in the low byte, upper bits zero
    wire [7:0] rd_val = (raddr == TMZ_ADDR_CNT)  ? cnt_r :
                        (raddr == TMZ_ADDR_ICTL) ? ictl_r :
                        (raddr == TMZ_ADDR_CFG)  ? cfg_r :
                        (raddr == TMZ_ADDR_STAT) ? {6'h00, stat_r} :
                        (raddr == TMZ_ADDR_MASK) ? {6'h00, mask_r} : 8'h00;
    wire       r_hit  = (raddr == TMZ_ADDR_CNT) || (raddr == TMZ_ADDR_ICTL)
                     || (raddr == TMZ_ADDR_CFG) || (raddr == TMZ_ADDR_STAT)
                     || (raddr == TMZ_ADDR_MASK);

    // read channel: one read in flight, answer one cycle after address
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= TMZ_RESP_OK;
        end else if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_val};
            s_axi_rresp   <= r_hit ? TMZ_RESP_OK : TMZ_RESP_ERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid;
        end
    end
    assign wdt_scaled_tick = wdt_r;
    assign overflow_irq    = ovf_irq_r;
    assign irq             = irq_r;
    // checks, all on the one clock
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_src_int;
        !cfg_src && cfg_psa && insn_tick && inh_r == 2'h0 && !cnt_wr
            |=> cnt_r == $past(cnt_r) + 8'h01;
    endproperty
    a_src_int: assert property (p_src_int)
        else $error("internal source did not step count");
    property p_edge_fall;
        cfg_src && cfg_edge && cfg_psa && pin_fall && inh_r == 2'h0
            && !cnt_wr |=> cnt_r == $past(cnt_r) + 8'h01;
    endproperty
    a_edge_fall: assert property (p_edge_fall)
        else $error("falling pin edge not counted");
    // timer-owned prescaler: watchdog tick is the base tick, one cycle on
    property p_excl;
        !$past(cfg_psa) |-> wdt_r == $past(wdt_base_tick);
    endproperty
    a_excl: assert property (p_excl)
        else $error("watchdog tick not unscaled while timer owns prescaler");
    property p_tmr_div;
        !cfg_psa && src_ev && ((psc_r & tmr_mask) != tmr_mask)
            |=> cnt_r == $past(cnt_r) || $past(cnt_wr);
    endproperty
    a_tmr_div: assert property (p_tmr_div)
        else $error("timer stepped before prescale period end");
    property p_wdt_div;
        cfg_psa && cfg_rate == 3'h0 && wdt_base_tick |=> wdt_r;
    endproperty
    a_wdt_div: assert property (p_wdt_div)
        else $error("watchdog rate 1:1 lost a tick");
    property p_ovf;
        inc_ev && cnt_r == 8'hff |=> cnt_r == 8'h00 && ictl_r[TMZ_ICTL_IF];
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow did not wrap and set flag");
    property p_inh;
        cnt_wr |=> inh_r == TMZ_INH_CYC && !inc_ev;
    endproperty
    a_inh: assert property (p_inh)
        else $error("count write did not hold increments");
    property p_psc_clr;
        cnt_wr && !cfg_psa |=> psc_r == 8'h00 && !cfg_psa;
    endproperty
    a_psc_clr: assert property (p_psc_clr)
        else $error("count write left prescaler or moved owner");
    property p_ie_mask;
        !ictl_r[TMZ_ICTL_IE] |=> !overflow_irq;
    endproperty
    a_ie_mask: assert property (p_ie_mask)
        else $error("overflow request while enable clear");
    property p_cfg_rst;
        @(posedge core_clk) disable iff (1'b0) rst |=> cfg_r == TMZ_CFG_RST;
    endproperty
    a_cfg_rst: assert property (p_cfg_rst)
        else $error("configuration not all ones after reset");
    c_ovf: cover property (ovf_ev);
    c_ext: cover property (cfg_src && inc_ev);
    c_cnt_wr: cover property (cnt_wr ##1 inh_r != 2'h0);
    c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == TMZ_RESP_ERR);
endmodule
`default_nettype wire

// File: test/tmz_pulse_src.sv
`timescale 1ns/1ns
`default_nettype none
// behavioural pulse source on the external count pin
module tmz_pulse_src (
    input  wire logic core_clk,
    output logic      pin
);
    int half;

    // pin idles low and stands still between bursts
    initial begin
        half = 4;
        pin  = 1'b0;
    end

    // one level change, then hold; the sync needs two clocks per level
    task automatic edge_to(input logic v);
        @(posedge core_clk);
        pin <= v;
        repeat (half) @(posedge core_clk);
    endtask

    // full pulses, one rising and one falling edge each
    task automatic pulses(input int n);
        repeat (n) begin
            edge_to(1'b1);
            edge_to(1'b0);
        end
    endtask
endmodule
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import tmz_pkg::*;
    typedef struct {
        string       name;
        logic [31:0] val;
        logic [31:0] msk;
        logic [1:0]  resp;
    } tmz_exp_t;
    logic        core_clk, rst, pin, tick, scaled, ovf_irq, irq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    tmz_exp_t    exp_q[$];
    tmz_exp_t    e;
    int          checks, fails, scaled_n, s0;
    logic [7:0]  v;

    tmz_pulse_src src (.core_clk(core_clk), .pin(pin));

    // short instruction cycle keeps the internal-source count test quick
    tmz_timer #(.INSN_DIV(2)) dut (
        .core_clk(core_clk), .rst(rst), .external_count_pin(pin),
        .wdt_base_tick(tick), .wdt_scaled_tick(scaled),
        .overflow_irq(ovf_irq), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic chk(input string n, input logic [31:0] x,
                       input logic [31:0] g);
        checks++;
        if (g !== x) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic final_report;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // write: address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] s = 4'hf,
                      input logic [1:0] r = TMZ_RESP_OK);
        exp_q.push_back('{"write", 32'h0, 32'h0, r});
        @(posedge core_clk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= {24'h0, d};
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask

    // read: expectation queued first, the monitor compares it
    task automatic rd(input string n, input logic [11:0] a,
                      input logic [7:0] x, input logic [7:0] m = 8'hff,
                      input logic [1:0] r = TMZ_RESP_OK);
        exp_q.push_back('{n, {24'h0, x}, {24'hffffff, m}, r});
        @(posedge core_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask

    // watchdog base ticks with random gaps
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge core_clk);
            tick <= 1'b1;
            @(posedge core_clk);
            tick <= 1'b0;
            repeat ($urandom_range(3)) @(posedge core_clk);
        end
        repeat (4) @(posedge core_clk);
    endtask

    // answer monitor: oldest expectation against each read or write answer
    always @(posedge core_clk) begin
        if (rvalid === 1'b1 && rready === 1'b1 ||
            bvalid === 1'b1 && bready === 1'b1) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("MISMATCH answer expected none seen one");
            end else begin
                e = exp_q.pop_front();
                if (rvalid === 1'b1) begin
                    chk(e.name, e.val, rdata & e.msk);
                    chk({e.name, " resp"}, {30'h0, e.resp}, {30'h0, rresp});
                end else begin
                    chk({e.name, " bresp"}, {30'h0, e.resp}, {30'h0, bresp});
                end
            end
        end
    end

    // scaled watchdog tick counter
    always @(posedge core_clk) begin
        if (scaled === 1'b1) scaled_n <= scaled_n + 1;
    end

    initial begin
        #200000;
        fails++;
        $display("MISMATCH watchdog expected finish seen hang");
        final_report();
    end

    initial begin
        awaddr   <= '0;
        araddr   <= '0;
        wdata    <= '0;
        awvalid  <= 1'b0;
        wvalid   <= 1'b0;
        bready   <= 1'b0;
        arvalid  <= 1'b0;
        rready   <= 1'b0;
        tick     <= 1'b0;
        wstrb    <= 4'hf;
        checks   = 0;
        fails    = 0;
        scaled_n = 0;
        rst   = 1'b1;
        v     = 8'($urandom(32'h9bd46116));
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        rd("config", TMZ_ADDR_CFG, 8'hff);
        rd("count", TMZ_ADDR_CNT, 8'h00);
        rd("intctl", TMZ_ADDR_ICTL, 8'h00);
        rd("unmapped", 12'h100, 8'h00, 8'hff, TMZ_RESP_ERR);
        // instruction-cycle source runs with the pin idle
        wr(TMZ_ADDR_CFG, 8'h08);
        wr(TMZ_ADDR_CNT, 8'h00);
        repeat (40) @(posedge core_clk);
        rd("count timer", TMZ_ADDR_CNT, 8'h10, 8'hf0);
        v = 8'($urandom_range(253));
        wr(TMZ_ADDR_CFG, 8'h28);
        wr(TMZ_ADDR_CNT, v);
        repeat (10) @(posedge core_clk);
        rd("count pin idle", TMZ_ADDR_CNT, v);
        // slow source: rising then falling edge selection
        src.half = 6;
        src.edge_to(1'b1);
        rd("rise counted", TMZ_ADDR_CNT, v + 8'h1);
        src.edge_to(1'b0);
        rd("fall ignored", TMZ_ADDR_CNT, v + 8'h1);
        wr(TMZ_ADDR_CFG, 8'h38);
        src.edge_to(1'b1);
        rd("rise ignored", TMZ_ADDR_CNT, v + 8'h1);
        src.edge_to(1'b0);
        rd("fall counted", TMZ_ADDR_CNT, v + 8'h2);
        // prompt source: every timer prescale code, one short and exact
        src.half = 3;
        for (int r = 0; r < 8; r++) begin
            wr(TMZ_ADDR_CFG, 8'h20 | 8'(r));
            wr(TMZ_ADDR_CNT, 8'h00);
            src.pulses((2 << r) - 1);
            rd("below ratio", TMZ_ADDR_CNT, 8'h00);
            src.pulses(1);
            rd("at ratio", TMZ_ADDR_CNT, 8'h01);
        end
        // half-filled prescaler must be dropped by a count write
        wr(TMZ_ADDR_CFG, 8'h20);
        src.pulses(1);
        wr(TMZ_ADDR_CNT, 8'h40);
        src.pulses(1);
        rd("prescaler cleared", TMZ_ADDR_CNT, 8'h40);
        rd("assign kept", TMZ_ADDR_CFG, 8'h20);
        // byte 0 strobe off and an unmapped address leave the count alone
        wr(TMZ_ADDR_CNT, v, 4'h0);
        wr(12'h100, v, 4'hf, TMZ_RESP_ERR);
        rd("strobe off", TMZ_ADDR_CNT, 8'h40);
        // safe move: clear prescaler before handing it over
        wr(TMZ_ADDR_CNT, 8'h00);
        for (int r = 0; r < 8; r++) begin
            wr(TMZ_ADDR_CFG, 8'h28 | 8'(r));
            s0 = scaled_n;
            ticks(2 << r);
            chk("scaled ticks", 32'h2, 32'(scaled_n - s0));
        end
        wr(TMZ_ADDR_CFG, 8'h27);
        s0 = scaled_n;
        ticks(3);
        chk("unscaled ticks", 32'h3, 32'(scaled_n - s0));
        // overflow, enable, status and mask
        wr(TMZ_ADDR_CFG, 8'h28);
        wr(TMZ_ADDR_CNT, 8'hff);
        src.pulses(1);
        rd("wrap", TMZ_ADDR_CNT, 8'h00);
        rd("flag", TMZ_ADDR_ICTL, 8'h04);
        chk("ovf irq masked", 32'h0, {31'h0, ovf_irq});
        wr(TMZ_ADDR_ICTL, 8'h24);
        chk("ovf irq", 32'h1, {31'h0, ovf_irq});
        rd("status", TMZ_ADDR_STAT, 8'h03);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(TMZ_ADDR_MASK, 8'h01);
        chk("irq", 32'h1, {31'h0, irq});
        wr(TMZ_ADDR_STAT, 8'h03);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd("status clear", TMZ_ADDR_STAT, 8'h00);
        wr(TMZ_ADDR_ICTL, 8'h20);
        chk("ovf irq off", 32'h0, {31'h0, ovf_irq});
        // a second reset in mid-run brings the registers back
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rd("config again", TMZ_ADDR_CFG, 8'hff);
        rd("intctl again", TMZ_ADDR_ICTL, 8'h00);
        repeat (4) @(posedge core_clk);
        final_report();
    end
endmodule
`default_nettype wire
